// >>> spp_i2c_host_model.sv
/*
 host model: an i2c controller that writes frames to the target.
 assumes an open-drain wire resolved by the bench with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_i2c_host_model #(
   parameter int QTR = 10 // quarter bit in clocks
) (
   input wire logic sys_clk,
   input wire logic sda_line, // resolved wire level
   output logic scl,
   output logic sda_low // high while we pull sda down
);
   // both lines released at time zero
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // wait whole clocks; all changes land just after an edge
   task automatic wq(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic start_cond();
      wq(QTR);
      sda_low <= 1'b1;
      wq(QTR);
      scl <= 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         wq(QTR);
         sda_low <= ~b[i];
         wq(QTR);
         scl <= 1'b1;
         wq(2 * QTR);
         scl <= 1'b0;
      end
      wq(QTR);
      sda_low <= 1'b0;
      wq(QTR);
      scl <= 1'b1;
      wq(QTR);
      ack = ~sda_line;
      wq(QTR);
      scl <= 1'b0;
   endtask
   task automatic stop_cond();
      wq(QTR);
      sda_low <= 1'b1;
      wq(QTR);
      scl <= 1'b1;
      wq(QTR);
      sda_low <= 1'b0;
      wq(2 * QTR);
   endtask
   // one frame, stops early on a refused header
   task automatic frame(input logic [7:0] hdr, input logic [7:0] cmd,
                        input logic [7:0] dat, input int nb, output logic hack);
      logic a;
      start_cond();
      send_byte(hdr, hack);
      if (hack && nb > 0) begin
         send_byte(cmd, a);
      end
      if (hack && nb > 1) begin
         send_byte(dat, a);
      end
      stop_cond();
   endtask
endmodule
`default_nettype wire

// >>> spp_i2c_target.sv
/*
 i2c target, 7-bit address, write path only: delivers received bytes.
 assumes scl/sda inputs already synchronous to sys_clk; open-drain pin as in/out/oe.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_i2c_target #(
   parameter logic [6:0] ADDR = spp_pkg::SPP_I2C_ADDR
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output spp_pkg::spp_byte_t rx_byte
);
   // all target state in one struct
   typedef struct packed {
      logic scl_d;
      logic sda_d;
      logic act;       // inside addressed transfer
      logic addr_ph;   // receiving address byte
      logic first;     // next data byte is first of transfer
      logic [3:0] bit_cnt;
      logic [7:0] shf;
      logic ack;       // driving ack low
      logic ack_pend;  // never set; ack is raised directly on the scl fall after the eighth bit
      logic [7:0] dat_r;
      logic val_r;
      logic fst_r;
   } spp_i2c_t;
   spp_i2c_t s_r, s_nxt;
   logic scl_rise, scl_fall, start_c, stop_c;
   // next-state logic; samples on scl rise, drives on scl fall
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_d = scl_in;
      s_nxt.sda_d = sda_in;
      s_nxt.val_r = 1'b0;
      scl_rise = scl_in & ~s_r.scl_d;
      scl_fall = ~scl_in & s_r.scl_d;
      start_c = scl_in & s_r.scl_d & s_r.sda_d & ~sda_in;
      stop_c = scl_in & s_r.scl_d & ~s_r.sda_d & sda_in;
      if (start_c) begin
         s_nxt.act = 1'b1;
         s_nxt.addr_ph = 1'b1;
         s_nxt.first = 1'b1;
         s_nxt.bit_cnt = 4'h0;
         s_nxt.ack = 1'b0;
      end else if (stop_c) begin
         s_nxt.act = 1'b0;
         s_nxt.ack = 1'b0;
      end else if (s_r.act && scl_rise && s_r.bit_cnt < 4'h8) begin
         s_nxt.shf = {s_r.shf[6:0], sda_in};
         s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      end else if (s_r.act && scl_fall) begin
         if (s_r.bit_cnt == 4'h8 && !s_r.ack) begin
            if (s_r.addr_ph) begin
               if (s_r.shf[7:1] == ADDR && !s_r.shf[0]) begin
                  s_nxt.ack = 1'b1;
                  s_nxt.addr_ph = 1'b0;
               end else begin
                  s_nxt.act = 1'b0;  // not ours or a read: stay silent
               end
            end else begin
               s_nxt.ack = 1'b1;
               s_nxt.val_r = 1'b1;
               s_nxt.dat_r = s_r.shf;
               s_nxt.fst_r = s_r.first;
               s_nxt.first = 1'b0;
            end
         end else if (s_r.ack) begin
            // release after the ack clock
            s_nxt.ack = 1'b0;
            s_nxt.bit_cnt = 4'h0;
         end
      end
      if (reset) begin
         s_nxt = '0;
         s_nxt.scl_d = 1'b1;
         s_nxt.sda_d = 1'b1;
      end
   end
   // edge-sampled logic is rate agnostic up to 1 Mbps at 40 MHz
   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end
   assign sda_out = 1'b0;
   assign sda_oe = s_r.ack;
   assign rx_byte = '{valid: s_r.val_r, first: s_r.fst_r, data: s_r.dat_r};
   // ack only after address match
   ack_match_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(s_r.ack) && $past(s_r.addr_ph) |-> $past(s_r.shf[7:1]) == ADDR)
      else $error("ack given to a foreign address");
   // a header that is not our write address gets no ack
   foreign_nak_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_r.act && s_r.addr_ph && scl_fall && s_r.bit_cnt == 4'h8 && s_r.shf != {ADDR, 1'b0}
      |=> !s_r.ack)
      else $error("ack given to a foreign header");
endmodule
`default_nettype wire

// >>> spp_pkg.sv
/*
 sink power-path policy package: shared constants, encodings and carrier structs.
 assumes a single 40 MHz clock domain and synchronous active-high reset.
*/
`default_nettype none
package spp_pkg;
   // clock rate and i2c target constants
   localparam int CLK_HZ = 40_000_000;
   localparam logic [6:0] SPP_I2C_ADDR = 7'h08;
   localparam int I2C_MAX_BPS = 1_000_000;
   // fallback contract figures, millivolts and milliamps
   localparam logic [15:0] SPP_SAFE_MV = 16'h1388;
   localparam logic [15:0] SPP_SAFE_MA = 16'h0384;
   // discharge hold time in microseconds and derived cycles
   localparam int DISCH_US = 650;
   localparam int DISCH_CYC = (DISCH_US * (CLK_HZ / 1_000_000));
   // i2c command codes written in the first data byte
   localparam logic [7:0] CMD_REENABLE = 8'h01;
   localparam logic [7:0] CMD_CFG_BYTE = 8'h02;
   localparam logic [7:0] CMD_FW_BYTE = 8'h03;
   localparam logic [7:0] CMD_COMMIT = 8'h04;
   // request from the policy to the contract negotiator
   typedef struct packed {
      logic req;
      logic [15:0] min_mv;
      logic [15:0] max_mv;
      logic [15:0] ma;
   } spp_req_t;
   // result back from the negotiator
   typedef struct packed {
      logic done;
      logic ok;
      logic [15:0] mv;
   } spp_res_t;
   // byte delivered by the i2c target
   typedef struct packed {
      logic valid;
      logic first;
      logic [7:0] data;
   } spp_byte_t;
   // policy states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_NEG = 6'h02,
      ST_MAIN = 6'h04,
      ST_SAFE_NEG = 6'h08,
      ST_SAFE = 6'h10,
      ST_FAULT = 6'h20
   } spp_state_t;
endpackage
`default_nettype wire

// >>> spp_policy.sv
/*
 sink power-path policy: main and fallback gates, detach discharge, fault pin,
 and host commands/config/firmware bytes via the i2c target.
 assumes an external contract negotiator, analog comparators already digital,
 and an external nonvolatile store that accepts byte writes with a ready.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_policy #(
   parameter int DISCH_CYCLES = spp_pkg::DISCH_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic attached,             // sink sees a source
   input wire logic [15:0] min_voltage_select,  // decoded min level, mV
   input wire logic [15:0] max_voltage_select,  // decoded max level, mV
   input wire logic [15:0] req_current_ma,
   output spp_pkg::spp_req_t neg_req,
   input wire spp_pkg::spp_res_t neg_res,
   input wire logic ovp,
   input wire logic ocp,
   input wire logic otp,
   output logic main_sink_gate,
   output logic fallback_power_gate,
   output logic vbus_discharge,
   output logic fault,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic nv_cfg_we,                // one-cycle store of cfg byte
   output logic nv_fw_we,                 // one-cycle store of firmware byte
   output logic [7:0] nv_data,
   output logic nv_commit,
   input wire logic nv_ready              // store can take a byte
);
   // whole policy state in one struct
   typedef struct packed {
      spp_pkg::spp_state_t st;
      spp_pkg::spp_req_t req;
      logic [15:0] mv;
      logic shortfall;    // source could not meet request
      logic prot_latch;   // ocp/otp trip awaiting re-enable
      logic [31:0] dis_cnt;
      logic disch;
      logic att_d;
      logic [7:0] cmd;
      logic cfg_we;
      logic fw_we;
      logic [7:0] nvd;
      logic commit;
   } spp_pol_t;
   spp_pol_t s_r, s_nxt;
   spp_pkg::spp_byte_t rx;
   logic reenable;

   // i2c target for host commands
   spp_i2c_target #(
      .ADDR(spp_pkg::SPP_I2C_ADDR)
   ) u_i2c (
      .sys_clk(sys_clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .rx_byte(rx)
   );

   // next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.att_d = attached;
      s_nxt.req.req = 1'b0;
      s_nxt.cfg_we = 1'b0;
      s_nxt.fw_we = 1'b0;
      s_nxt.commit = 1'b0;
      reenable = 1'b0;
      // host byte decode: first byte is command, rest are payload
      if (rx.valid) begin
         if (rx.first) begin
            s_nxt.cmd = rx.data;
            reenable = (rx.data == spp_pkg::CMD_REENABLE);
            s_nxt.commit = (rx.data == spp_pkg::CMD_COMMIT);
         end else if (nv_ready) begin
            s_nxt.cfg_we = (s_r.cmd == spp_pkg::CMD_CFG_BYTE);
            s_nxt.fw_we = (s_r.cmd == spp_pkg::CMD_FW_BYTE);
            s_nxt.nvd = rx.data;
         end
      end
      // protection trip latches; trip wins over re-enable
      if (ocp || otp) begin
         s_nxt.prot_latch = 1'b1;
      end else if (reenable) begin
         s_nxt.prot_latch = 1'b0;
      end
      if (s_r.att_d && !attached) begin
         s_nxt.disch = 1'b1;
         s_nxt.dis_cnt = 32'(DISCH_CYCLES);
      end else if (s_r.disch) begin
         if (s_r.dis_cnt <= 32'h1 || attached) begin
            s_nxt.disch = 1'b0;
            s_nxt.dis_cnt = 32'h0;
         end else begin
            s_nxt.dis_cnt = s_r.dis_cnt - 32'h1;
         end
      end
      unique case (s_r.st)
         spp_pkg::ST_IDLE: begin
            s_nxt.shortfall = 1'b0;
            if (attached && !s_r.prot_latch) begin
               s_nxt.req.min_mv = min_voltage_select;
               s_nxt.req.max_mv = max_voltage_select;
               s_nxt.req.ma = req_current_ma;
               s_nxt.req.req = 1'b1;
               s_nxt.st = spp_pkg::ST_NEG;
            end
         end
         spp_pkg::ST_NEG: begin
            if (neg_res.done) begin
               if (neg_res.ok && neg_res.mv >= s_r.req.min_mv
                   && neg_res.mv <= s_r.req.max_mv) begin
                  s_nxt.mv = neg_res.mv;
                  s_nxt.st = spp_pkg::ST_MAIN;
               end else begin
                  // fall back to 5 V 900 mA
                  s_nxt.shortfall = 1'b1;
                  s_nxt.req = '{req: 1'b1, min_mv: spp_pkg::SPP_SAFE_MV,
                                max_mv: spp_pkg::SPP_SAFE_MV, ma: spp_pkg::SPP_SAFE_MA};
                  s_nxt.st = spp_pkg::ST_SAFE_NEG;
               end
            end
         end
         spp_pkg::ST_SAFE_NEG: begin
            if (neg_res.done) begin
               s_nxt.mv = neg_res.mv;
               s_nxt.st = spp_pkg::ST_SAFE;
            end
         end
         spp_pkg::ST_MAIN, spp_pkg::ST_SAFE: begin
            // a held contract just waits for detach or trip
         end
         spp_pkg::ST_FAULT: begin
            if (!s_r.prot_latch) begin
               s_nxt.st = spp_pkg::ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = spp_pkg::ST_IDLE;
         end
      endcase
      // trip and detach override whatever state was chosen
      if (ocp || otp || s_r.prot_latch) begin
         s_nxt.st = spp_pkg::ST_FAULT;
      end else if (!attached) begin
         s_nxt.st = spp_pkg::ST_IDLE;
      end
      if (reset) begin
         s_nxt = '0;
         s_nxt.st = spp_pkg::ST_IDLE;
      end
   end

   // single register for all state
   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end

   // main gate only in accepted contract
   assign main_sink_gate = (s_r.st == spp_pkg::ST_MAIN);
   // fallback gate on after failed contract
   assign fallback_power_gate = (s_r.st == spp_pkg::ST_SAFE);
   assign vbus_discharge = s_r.disch;
   assign fault = s_r.shortfall | s_r.prot_latch | ovp;
   assign neg_req = s_r.req;
   assign nv_cfg_we = s_r.cfg_we;
   assign nv_fw_we = s_r.fw_we;
   assign nv_data = s_r.nvd;
   assign nv_commit = s_r.commit;

   // gates never on together
   gates_exclusive_a: assert property (@(posedge sys_clk) disable iff (reset)
      !(main_sink_gate && fallback_power_gate))
      else $error("both gates on");
   // main gate needs in-window voltage
   main_window_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(main_sink_gate) |-> s_r.mv >= s_r.req.min_mv && s_r.mv <= s_r.req.max_mv)
      else $error("main gate outside voltage window");
   // failed contract leads to safe request
   safe_request_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_r.st == spp_pkg::ST_NEG && neg_res.done && !neg_res.ok && attached
      && !ocp && !otp |=> s_r.req.min_mv == 16'h1388 && s_r.req.ma == 16'h0384)
      else $error("fallback request not 5 V 900 mA");
   // fallback gate follows safe contract
   fallback_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_r.st == spp_pkg::ST_SAFE_NEG && neg_res.done && attached && !ocp && !otp
      && !s_r.prot_latch |=> fallback_power_gate)
      else $error("fallback gate not enabled");
   // request samples select inputs
   min_sample_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(s_r.req.req) && s_r.st == spp_pkg::ST_NEG
      |-> s_r.req.min_mv == $past(min_voltage_select))
      else $error("min voltage not taken from select");
   max_sample_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(s_r.req.req) && s_r.st == spp_pkg::ST_NEG
      |-> s_r.req.max_mv == $past(max_voltage_select))
      else $error("max voltage not taken from select");
   // detach starts discharge next cycle
   detach_disch_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_r.att_d && !attached |=> vbus_discharge)
      else $error("no discharge on detach");
   // either trip shuts gates and raises fault
   trip_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      ocp || otp |=> !main_sink_gate && !fallback_power_gate && fault)
      else $error("path not off after trip");
   // a good contract with no overvoltage keeps the fault pin low
   fault_low_a: assert property (@(posedge sys_clk) disable iff (reset)
      main_sink_gate && !ovp |-> !fault)
      else $error("fault high in a good contract");
   // config byte written only with store ready
   cfg_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      nv_cfg_we |-> $past(nv_ready) && $past(rx.valid))
      else $error("config write without ready byte");
endmodule
`default_nettype wire

// >>> spp_policy_tb.sv
/*
 bench for the power-path policy: negotiator played by tasks, host model on i2c.
 assumes 40 MHz clock and a short discharge hold parameter.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_policy_tb;
   localparam int DISCH = 20; // short hold keeps the run brief
   logic sys_clk = 1'b0;
   logic reset, attached, ovp, ocp, otp, nv_ready, ack;
   logic main_sink_gate, fallback_power_gate, vbus_discharge, fault;
   logic scl, sda_low, sda_line, sda_out, sda_oe, nv_cfg_we, nv_fw_we, nv_commit;
   logic [15:0] min_voltage_select, max_voltage_select, req_current_ma;
   logic [7:0] nv_data, cfg_seen, fw_seen;
   spp_pkg::spp_req_t neg_req;
   spp_pkg::spp_res_t neg_res;
   int err_total = 0, n_tests = 0, cyc = 0, cfg_n = 0, fw_n = 0, com_n = 0;
   // open drain with pull-up: low if anyone pulls
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   always #12.5 sys_clk = ~sys_clk;
   spp_policy #(.DISCH_CYCLES(DISCH)) uut (.sys_clk, .reset, .attached,
      .min_voltage_select, .max_voltage_select, .req_current_ma, .neg_req, .neg_res,
      .ovp, .ocp, .otp, .main_sink_gate, .fallback_power_gate, .vbus_discharge, .fault,
      .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .nv_cfg_we, .nv_fw_we,
      .nv_data, .nv_commit, .nv_ready);
   spp_i2c_host_model i2c (.sys_clk, .sda_line, .scl, .sda_low);
   // store pulses counted, data captured; also the hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (nv_cfg_we === 1'b1) begin
         cfg_n++;
         cfg_seen = nv_data;
      end
      if (nv_fw_we === 1'b1) begin
         fw_n++;
         fw_seen = nv_data;
      end
      if (nv_commit === 1'b1) begin
         com_n++;
      end
      if (cyc == 40000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // bounded wait for a request pulse
   task automatic wait_req();
      for (int k = 0; k < 100 && neg_req.req !== 1'b1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("req", neg_req.req, 1);
   endtask
   // negotiator answer: one-cycle done
   task automatic answer(input logic ok, input logic [15:0] mv);
      @(posedge sys_clk);
      neg_res <= '{1'b1, ok, mv};
      @(posedge sys_clk);
      neg_res <= '0;
      #1;
   endtask
   task automatic test_main();
      @(posedge sys_clk);
      min_voltage_select <= 16'h2328;
      max_voltage_select <= 16'h3a98;
      attached <= 1'b1;
      #1;
      wait_req();
      chk("min", neg_req.min_mv, 16'h2328);
      chk("max", neg_req.max_mv, 16'h3a98);
      chk("ma", neg_req.ma, 16'h0bb8);
      chk("main_early", main_sink_gate, 0);
      answer(1'b1, 16'h2ee0);
      chk("main", main_sink_gate, 1);
      chk("fb", fallback_power_gate, 0);
      chk("fault", fault, 0);
   endtask
   task automatic test_detach();
      @(posedge sys_clk);
      attached <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("dis_on", vbus_discharge, 1);
      chk("gates", {main_sink_gate, fallback_power_gate}, 0);
      repeat (DISCH - 1) @(posedge sys_clk);
      #1;
      chk("dis_hold", vbus_discharge, 1);
      @(posedge sys_clk);
      #1;
      chk("dis_end", vbus_discharge, 0);
   endtask
   // reattach cuts a running discharge short
   task automatic test_reattach();
      test_main();
      @(posedge sys_clk);
      attached <= 1'b0;
      repeat (3) @(posedge sys_clk);
      attached <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("re_dis", vbus_discharge, 0);
      test_detach();
   endtask
   // refused contract: either a failure or a voltage outside the window
   task automatic test_fallback(input logic ok, input logic [15:0] mv);
      @(posedge sys_clk);
      attached <= 1'b1;
      #1;
      wait_req();
      answer(ok, mv);
      wait_req();
      chk("fb_min", neg_req.min_mv, spp_pkg::SPP_SAFE_MV);
      chk("fb_max", neg_req.max_mv, spp_pkg::SPP_SAFE_MV);
      chk("fb_ma", neg_req.ma, spp_pkg::SPP_SAFE_MA);
      chk("fb_fault", fault, 1);
      answer(1'b1, spp_pkg::SPP_SAFE_MV);
      chk("fb_on", fallback_power_gate, 1);
      chk("fb_main", main_sink_gate, 0);
      test_detach();
   endtask
   task automatic test_trip(input logic temp);
      test_main();
      @(posedge sys_clk);
      ocp <= ~temp;
      otp <= temp;
      @(posedge sys_clk);
      ocp <= 1'b0;
      otp <= 1'b0;
      attached <= 1'b0;
      #1;
      chk("trip_main", main_sink_gate, 0);
      chk("trip_fault", fault, 1);
      repeat (30) @(posedge sys_clk);
      #1;
      chk("latched", fault, 1);
      i2c.frame(8'h10, spp_pkg::CMD_REENABLE, 8'h00, 1, ack);
      chk("ack", ack, 1);
      chk("cleared", fault, 0);
      @(posedge sys_clk);
      ovp <= 1'b1;
      #1;
      chk("ovp", fault, 1);
      @(posedge sys_clk);
      ovp <= 1'b0;
      #1;
      chk("ovp_off", fault, 0);
      test_main();
      test_detach();
   endtask
   task automatic test_store();
      i2c.frame(8'h12, spp_pkg::CMD_CFG_BYTE, 8'h77, 2, ack);
      chk("other_addr", ack, 0);
      i2c.frame(8'h11, spp_pkg::CMD_CFG_BYTE, 8'h77, 2, ack);
      chk("read_dir", ack, 0);
      i2c.frame(8'h10, spp_pkg::CMD_CFG_BYTE, 8'ha5, 2, ack);
      chk("cfg_n", cfg_n[15:0], 1);
      chk("cfg_d", cfg_seen, 8'ha5);
      chk("fw_none", fw_n[15:0], 0);
      i2c.frame(8'h10, spp_pkg::CMD_FW_BYTE, 8'h3c, 2, ack);
      chk("fw_n", fw_n[15:0], 1);
      chk("fw_d", fw_seen, 8'h3c);
      i2c.frame(8'h10, spp_pkg::CMD_COMMIT, 8'h00, 1, ack);
      chk("commit", com_n[15:0], 1);
      @(posedge sys_clk);
      nv_ready <= 1'b0;
      i2c.frame(8'h10, spp_pkg::CMD_CFG_BYTE, 8'h5a, 2, ack);
      chk("busy_drop", cfg_n[15:0], 1);
   endtask
   initial begin
      reset = 1'b1;
      {attached, ovp, ocp, otp} = 4'h0;
      nv_ready = 1'b1;
      min_voltage_select = 16'h0000;
      max_voltage_select = 16'h0000;
      req_current_ma = 16'h0bb8;
      neg_res = '0;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("rst_out", {main_sink_gate, fallback_power_gate, vbus_discharge, sda_oe}, 0);
      test_main();
      test_detach();
      test_reattach();
      test_fallback(1'b0, 16'h0000);
      test_fallback(1'b1, 16'h4e20);
      test_fallback(1'b1, 16'h1388);
      test_trip(1'b0);
      test_trip(1'b1);
      test_store();
      close_out();
   end
endmodule
`default_nettype wire
